// ==== npcf_pkg.sv ====
`default_nettype none
package npcf_pkg;
  // Credit count width and saturation limit
  localparam int unsigned CNT_W       = 6;
  localparam logic [5:0]  CNT_MAX     = 6'h20;
  localparam logic [5:0]  CNT_RST     = 6'h00;
  // Transmit credit indicator encodings
  localparam logic [1:0]  AV_NONE     = 2'h0;
  localparam logic [1:0]  AV_ONE      = 2'h1;
  localparam logic [1:0]  AV_TWO      = 2'h2;
  localparam logic [1:0]  AV_MANY     = 2'h3;
  // Transmit credit pool width and reset value
  localparam int unsigned POOL_W      = 8;
  localparam logic [7:0]  POOL_RST    = 8'h00;
  localparam logic [7:0]  POOL_MAX    = 8'hff;
  // Indicator lag in cycles
  localparam int unsigned AV_LAG      = 2;
  // Tag reuse guard after a completion, in user clocks
  localparam int unsigned TAG_GUARD   = 5;
  localparam logic [2:0]  TAG_GRD_CNT = 3'h5;
  localparam int unsigned TAG_W       = 8;
  localparam int unsigned DATA_W      = 32;
endpackage : npcf_pkg
`default_nettype wire

// ==== npcf_if.sv ====
`default_nettype none
interface npcf_if;
  logic                            np_delivery_credit_request;
  logic [npcf_pkg::CNT_W-1:0]      np_delivery_credit_level;
  // Completer request stream
  logic                            cq_valid;
  logic                            cq_ready;
  logic                            cq_np;
  logic [npcf_pkg::DATA_W-1:0]     cq_data;
  // Transmit credit indicators
  logic [1:0]                      tx_np_header_credit_avail;
  logic [1:0]                      tx_np_payload_credit_avail;
  logic                            rq_np_sent;
  logic                            rq_np_has_payload;
  // Requester completion sideband
  logic                            requester_completion_sideband;
  logic [npcf_pkg::TAG_W-1:0]      rc_tag;

  modport core (
    input  np_delivery_credit_request,
    output np_delivery_credit_level,
    output cq_valid,
    input  cq_ready,
    output cq_np,
    output cq_data,
    output tx_np_header_credit_avail,
    output tx_np_payload_credit_avail,
    input  rq_np_sent,
    input  rq_np_has_payload,
    output requester_completion_sideband,
    output rc_tag
  );
  modport user (
    output np_delivery_credit_request,
    input  np_delivery_credit_level,
    input  cq_valid,
    output cq_ready,
    input  cq_np,
    input  cq_data,
    input  tx_np_header_credit_avail,
    input  tx_np_payload_credit_avail,
    output rq_np_sent,
    output rq_np_has_payload,
    input  requester_completion_sideband,
    input  rc_tag
  );
endinterface : npcf_if
`default_nettype wire

// ==== npcf_core.sv ====
`default_nettype none
module npcf_core (
  input  wire logic                        sys_clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        clk_en_i,
  npcf_if.core                             lnk,
  // Packets received from the link
  input  wire logic                        rx_valid_i,
  input  wire logic                        rx_np_i,
  input  wire logic [npcf_pkg::DATA_W-1:0] rx_data_i,
  output logic                             rx_ready_o,
  // Transmit credit returned by the link partner
  input  wire logic                        tx_nph_return_i,
  input  wire logic                        tx_npd_return_i,
  // Completion presented toward the user
  input  wire logic                        cpl_valid_i,
  input  wire logic [npcf_pkg::TAG_W-1:0]  cpl_tag_i
);
  // ==========================================================
  // Non-posted delivery credit
  logic [npcf_pkg::CNT_W-1:0] cnt_ff;
  logic [npcf_pkg::CNT_W-1:0] nxt_cnt;
  logic                       np_give;
  logic                       credit_ok;

  assign credit_ok = (cnt_ff != npcf_pkg::CNT_RST);

  always_comb begin
    nxt_cnt = cnt_ff;
    if (lnk.np_delivery_credit_request && !np_give &&
        cnt_ff != npcf_pkg::CNT_MAX) begin
      nxt_cnt = cnt_ff + 6'h01;
    end else if (np_give && !lnk.np_delivery_credit_request) begin
      nxt_cnt = cnt_ff - 6'h01;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cnt_ff <= npcf_pkg::CNT_RST;
    end else if (clk_en_i) begin
      cnt_ff <= nxt_cnt;
    end
  end

  // ==========================================================
  // Credit level output
  // Level is registered, one cycle after the count
  logic [npcf_pkg::CNT_W-1:0] lvl_ff;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      lvl_ff <= npcf_pkg::CNT_RST;
    end else if (clk_en_i) begin
      lvl_ff <= cnt_ff;
    end
  end
  assign lnk.np_delivery_credit_level = lvl_ff;

  // ==========================================================
  // Completer request output register
  logic                        ov_ff;
  logic                        onp_ff;
  logic [npcf_pkg::DATA_W-1:0] od_ff;
  logic                        nxt_ov;
  logic                        nxt_onp;
  logic [npcf_pkg::DATA_W-1:0] nxt_od;
  logic                        slot_free;
  logic                        rx_take;

  assign slot_free  = !ov_ff || lnk.cq_ready;
  // Posted packets never wait on credit
  assign rx_ready_o = slot_free && (!rx_np_i || credit_ok);
  assign rx_take    = rx_valid_i && rx_ready_o;
  assign np_give    = rx_take && rx_np_i;

  always_comb begin
    nxt_ov  = ov_ff;
    nxt_onp = onp_ff;
    nxt_od  = od_ff;
    if (slot_free) begin
      nxt_ov = rx_take;
      if (rx_take) begin
        nxt_onp = rx_np_i;
        nxt_od  = rx_data_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ov_ff  <= 1'b0;
      onp_ff <= 1'b0;
      od_ff  <= '0;
    end else if (clk_en_i) begin
      ov_ff  <= nxt_ov;
      onp_ff <= nxt_onp;
      od_ff  <= nxt_od;
    end
  end
  assign lnk.cq_valid = ov_ff;
  assign lnk.cq_np    = onp_ff;
  assign lnk.cq_data  = od_ff;

  // ==========================================================
  // Transmit credit pools and indicators
  logic [npcf_pkg::POOL_W-1:0] nph_ff;
  logic [npcf_pkg::POOL_W-1:0] npd_ff;
  logic [npcf_pkg::POOL_W-1:0] nxt_nph;
  logic [npcf_pkg::POOL_W-1:0] nxt_npd;
  logic [1:0]                  hav_ff;
  logic [1:0]                  dav_ff;
  logic [1:0]                  hav_d_ff;
  logic [1:0]                  dav_d_ff;

  // ==========================================================
  // Pool helpers: two-bit code and saturating update
  function automatic logic [1:0] npcf_enc(
    input logic [npcf_pkg::POOL_W-1:0] v
  );
    if (v == 8'h00) begin
      npcf_enc = npcf_pkg::AV_NONE;
    end else if (v == 8'h01) begin
      npcf_enc = npcf_pkg::AV_ONE;
    end else if (v == 8'h02) begin
      npcf_enc = npcf_pkg::AV_TWO;
    end else begin
      npcf_enc = npcf_pkg::AV_MANY;
    end
  endfunction : npcf_enc

  function automatic logic [npcf_pkg::POOL_W-1:0] npcf_upd(
    input logic [npcf_pkg::POOL_W-1:0] v,
    input logic                        add,
    input logic                        sub
  );
    npcf_upd = v;
    if (add && !sub && v != npcf_pkg::POOL_MAX) begin
      npcf_upd = v + 8'h01;
    end else if (sub && !add && v != npcf_pkg::POOL_RST) begin
      npcf_upd = v - 8'h01;
    end
  endfunction : npcf_upd

  always_comb begin
    nxt_nph = npcf_upd(nph_ff, tx_nph_return_i, lnk.rq_np_sent);
    nxt_npd = npcf_upd(npd_ff, tx_npd_return_i,
                       lnk.rq_np_sent && lnk.rq_np_has_payload);
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      nph_ff   <= npcf_pkg::POOL_RST;
      npd_ff   <= npcf_pkg::POOL_RST;
      hav_ff   <= npcf_pkg::AV_NONE;
      dav_ff   <= npcf_pkg::AV_NONE;
      hav_d_ff <= npcf_pkg::AV_NONE;
      dav_d_ff <= npcf_pkg::AV_NONE;
    end else if (clk_en_i) begin
      nph_ff   <= nxt_nph;
      npd_ff   <= nxt_npd;
      // Two-stage pipe: recent use may be missing
      hav_ff   <= npcf_enc(nph_ff);
      dav_ff   <= npcf_enc(npd_ff);
      hav_d_ff <= hav_ff;
      dav_d_ff <= dav_ff;
    end
  end
  // Indicators trail the pools by two edges
  assign lnk.tx_np_header_credit_avail  = hav_d_ff;
  assign lnk.tx_np_payload_credit_avail = dav_d_ff;

  // ==========================================================
  // Completion sideband
  logic                       cv_ff;
  logic [npcf_pkg::TAG_W-1:0] ct_ff;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cv_ff <= 1'b0;
      ct_ff <= '0;
    end else if (clk_en_i) begin
      cv_ff <= cpl_valid_i;
      ct_ff <= cpl_valid_i ? cpl_tag_i : ct_ff;
    end
  end
  assign lnk.requester_completion_sideband = cv_ff;
  assign lnk.rc_tag                        = ct_ff;
endmodule : npcf_core
`default_nettype wire

// ==== npcf_user.sv ====
`default_nettype none
module npcf_user (
  input  wire logic                        sys_clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        clk_en_i,
  npcf_if.user                             lnk,
  // User-side controls
  input  wire logic                        hold_credit_i,
  input  wire logic                        grant_pulse_i,
  input  wire logic                        sink_ready_i,
  output logic                             pkt_valid_o,
  output logic                             pkt_np_o,
  output logic [npcf_pkg::DATA_W-1:0]      pkt_data_o,
  input  wire logic                        np_send_req_i,
  input  wire logic                        np_send_payload_i,
  output logic                             np_send_ack_o,
  output logic                             tag_free_o,
  output logic [npcf_pkg::TAG_W-1:0]       tag_free_id_o
);
  // ==========================================================
  // Credit grant: held level or one pulse per request
  assign lnk.np_delivery_credit_request =
    hold_credit_i || grant_pulse_i;
  assign lnk.cq_ready = sink_ready_i;

  logic                        pv_ff;
  logic                        pn_ff;
  logic [npcf_pkg::DATA_W-1:0] pd_ff;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pv_ff <= 1'b0;
      pn_ff <= 1'b0;
      pd_ff <= '0;
    end else if (clk_en_i) begin
      pv_ff <= lnk.cq_valid && lnk.cq_ready;
      pn_ff <= lnk.cq_np;
      pd_ff <= lnk.cq_data;
    end
  end
  assign pkt_valid_o = pv_ff;
  assign pkt_np_o    = pn_ff;
  assign pkt_data_o  = pd_ff;

  // ==========================================================
  // Transmit gate: indicator minus own recent sends
  logic [1:0] s1_ff;
  logic [1:0] s2_ff;
  logic [2:0] h_used;
  logic [2:0] d_used;
  logic       ok;
  always_comb begin
    h_used = {2'b00, s1_ff[0]} + {2'b00, s2_ff[0]};
    d_used = {2'b00, s1_ff[1]} + {2'b00, s2_ff[1]};
    ok = ({1'b0, lnk.tx_np_header_credit_avail} > h_used) &&
         (!np_send_payload_i ||
          {1'b0, lnk.tx_np_payload_credit_avail} > d_used);
  end
  assign np_send_ack_o         = np_send_req_i && ok;
  assign lnk.rq_np_sent        = np_send_ack_o;
  assign lnk.rq_np_has_payload = np_send_payload_i;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s1_ff <= 2'h0;
      s2_ff <= 2'h0;
    end else if (clk_en_i) begin
      s1_ff <= {np_send_ack_o && np_send_payload_i, np_send_ack_o};
      s2_ff <= s1_ff;
    end
  end

  // ==========================================================
  // Tag reuse guard
  logic [2:0]                 tg_ff;
  logic [2:0]                 nxt_tg;
  logic [npcf_pkg::TAG_W-1:0] tid_ff;
  logic                       tf_ff;
  always_comb begin
    nxt_tg = tg_ff;
    if (lnk.requester_completion_sideband) begin
      nxt_tg = npcf_pkg::TAG_GRD_CNT;
    end else if (tg_ff != 3'h0) begin
      nxt_tg = tg_ff - 3'h1;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      tg_ff  <= 3'h0;
      tid_ff <= '0;
      tf_ff  <= 1'b0;
    end else if (clk_en_i) begin
      tg_ff  <= nxt_tg;
      tid_ff <= lnk.requester_completion_sideband ? lnk.rc_tag : tid_ff;
      tf_ff  <= (tg_ff == 3'h1) && !lnk.requester_completion_sideband;
    end
  end
  assign tag_free_o    = tf_ff;
  assign tag_free_id_o = tid_ff;
endmodule : npcf_user
`default_nettype wire

// ==== npcf_checker.sv ====
`default_nettype none
module npcf_checker (
  input wire logic       sys_clk_i,
  input wire logic       rst_n_i,
  input wire logic       np_delivery_credit_request,
  input wire logic [5:0] np_delivery_credit_level,
  input wire logic       cq_valid,
  input wire logic       cq_ready,
  input wire logic       cq_np,
  input wire logic [1:0] tx_np_header_credit_avail,
  input wire logic [1:0] tx_np_payload_credit_avail,
  input wire logic       rq_np_sent,
  input wire logic       rq_np_has_payload
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========================================
  // Credit count reference, one cycle late
  logic [5:0] mdl_ff;
  logic [5:0] nxt_mdl;
  logic       req_d_ff;
  logic       vld_d_ff;
  logic       rdy_d_ff;
  logic       new_np;
  logic       pld_sent;
  assign pld_sent = rq_np_sent && rq_np_has_payload;
  always_comb begin
    new_np  = cq_valid && cq_np && (!vld_d_ff || rdy_d_ff);
    nxt_mdl = mdl_ff;
    if (req_d_ff && !new_np && mdl_ff < npcf_pkg::CNT_MAX) begin
      nxt_mdl = mdl_ff + 6'h01;
    end else if (new_np && !req_d_ff) begin
      nxt_mdl = mdl_ff - 6'h01;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      mdl_ff   <= npcf_pkg::CNT_RST;
      req_d_ff <= 1'b0;
      vld_d_ff <= 1'b0;
      rdy_d_ff <= 1'b0;
    end else begin
      mdl_ff   <= nxt_mdl;
      req_d_ff <= np_delivery_credit_request;
      vld_d_ff <= cq_valid;
      rdy_d_ff <= cq_ready;
    end
  end
  // ========================================
  // Properties
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_LEVEL_TRACK: assert property (
    np_delivery_credit_level == mdl_ff)
    else $error("credit level off its request history");
  AST_RESET_LEVEL: assert property (
    $rose(rst_n_i) |-> np_delivery_credit_level == 6'h00 && !cq_valid)
    else $error("credit level not cleared by reset");
  AST_LEVEL_SAT: assert property (
    np_delivery_credit_level <= npcf_pkg::CNT_MAX)
    else $error("credit level above its limit");
  AST_NP_GATED: assert property (
    new_np |-> mdl_ff != 6'h00)
    else $error("non-posted request delivered without credit");
  AST_HDR_GATE: assert property (
    rq_np_sent |-> tx_np_header_credit_avail >
      ($past(rq_np_sent) + $past(rq_np_sent, 2)))
    else $error("request sent beyond header credit");
  AST_PLD_GATE: assert property (
    pld_sent |-> tx_np_payload_credit_avail >
      ($past(pld_sent) + $past(pld_sent, 2)))
    else $error("request sent beyond payload credit");
  AST_HDR_DROP: assert property (
    tx_np_header_credit_avail < $past(tx_np_header_credit_avail) |->
      $past(rq_np_sent, 3) && $past(tx_np_header_credit_avail) ==
      tx_np_header_credit_avail + 2'h1)
    else $error("header credit fell without a send");
  AST_PLD_DROP: assert property (
    tx_np_payload_credit_avail < $past(tx_np_payload_credit_avail) |->
      $past(pld_sent, 3) && $past(tx_np_payload_credit_avail) ==
      tx_np_payload_credit_avail + 2'h1)
    else $error("payload credit fell without a send");
endmodule : npcf_checker
`default_nettype wire

// ==== tb_top.sv ====
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ========================================
  // Stimulus and observation
  logic        sys_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        rx_valid = 1'b0, rx_np = 1'b0, nph_ret = 1'b0;
  logic        npd_ret = 1'b0, cpl_valid = 1'b0, hold_cr = 1'b0;
  logic        grant = 1'b0, send_req = 1'b0, send_pld = 1'b0;
  logic [31:0] rx_data = 32'h0, pkt_data;
  logic [7:0]  cpl_tag = 8'h00, free_id;
  logic        rx_ready, pkt_valid, pkt_np, send_ack, tag_free;
  logic [5:0]  lvl;
  logic [1:0]  hav, dav;
  logic        sband;
  int          mismatches = 0;
  int          total_checks = 0;
  int          cycles = 0;
  npcf_if lnk_if ();
  assign lvl   = lnk_if.np_delivery_credit_level;
  assign hav   = lnk_if.tx_np_header_credit_avail;
  assign dav   = lnk_if.tx_np_payload_credit_avail;
  assign sband = lnk_if.requester_completion_sideband;
  npcf_core i_npcf_core (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .clk_en_i(1'b1), .lnk(lnk_if), .rx_valid_i(rx_valid),
    .rx_np_i(rx_np), .rx_data_i(rx_data), .rx_ready_o(rx_ready),
    .tx_nph_return_i(nph_ret), .tx_npd_return_i(npd_ret),
    .cpl_valid_i(cpl_valid), .cpl_tag_i(cpl_tag));
  npcf_user i_npcf_user (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .clk_en_i(1'b1), .lnk(lnk_if), .hold_credit_i(hold_cr),
    .grant_pulse_i(grant), .sink_ready_i(1'b1), .pkt_valid_o(pkt_valid),
    .pkt_np_o(pkt_np), .pkt_data_o(pkt_data), .np_send_req_i(send_req),
    .np_send_payload_i(send_pld), .np_send_ack_o(send_ack),
    .tag_free_o(tag_free), .tag_free_id_o(free_id));
  npcf_checker i_npcf_checker (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .np_delivery_credit_request(lnk_if.np_delivery_credit_request),
    .np_delivery_credit_level(lnk_if.np_delivery_credit_level),
    .cq_valid(lnk_if.cq_valid), .cq_ready(lnk_if.cq_ready),
    .cq_np(lnk_if.cq_np),
    .tx_np_header_credit_avail(lnk_if.tx_np_header_credit_avail),
    .tx_np_payload_credit_avail(lnk_if.tx_np_payload_credit_avail),
    .rq_np_sent(lnk_if.rq_np_sent),
    .rq_np_has_payload(lnk_if.rq_np_has_payload));
  always #20 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      stop_test();
    end
  end
  // ========================================
  // Shared tasks
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic tick(int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : tick
  function automatic logic [1:0] enc(int n);
    return (n >= 3) ? npcf_pkg::AV_MANY : 2'(n);
  endfunction : enc
  task automatic rx_pkt(logic np, logic [31:0] d, logic exp_rdy);
    rx_valid = 1'b1;
    rx_np    = np;
    rx_data  = d;
    #1;
    check("rx_ready_o", 32'(rx_ready), 32'(exp_rdy));
    tick(1);
    rx_valid = 1'b0;
    if (exp_rdy) begin
      tick(1);
      check("pkt_valid_o", 32'(pkt_valid), 32'h1);
      check("pkt_np_o", 32'(pkt_np), 32'(np));
      check("pkt_data_o", pkt_data, d);
    end
    tick(1);
  endtask : rx_pkt
  task automatic level_is(logic [5:0] exp);
    check("credit level", 32'(lvl), 32'(exp));
  endtask : level_is
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  // ========================================
  // Scenarios
  task automatic do_reset();
    rst_n_i = 1'b0;
    tick(20);
    rst_n_i = 1'b1;
  endtask : do_reset
  task automatic test_reset();
    level_is(6'h00);
    check("hdr avail", 32'(hav), 32'h0);
    check("pld avail", 32'(dav), 32'h0);
    rx_pkt(1'b1, 32'hdead0001, 1'b0);
    rx_pkt(1'b0, 32'h1234abcd, 1'b1);
    $display("test_reset done");
  endtask : test_reset
  task automatic test_np_credit();
    repeat (3) begin
      grant = 1'b1;
      tick(1);
      grant = 1'b0;
      tick(1);
    end
    tick(2);
    level_is(6'h03);
    for (int i = 0; i < 3; i++) rx_pkt(1'b1, 32'hc0de0000 + 32'(i), 1'b1);
    rx_pkt(1'b1, 32'hc0de00ff, 1'b0);
    rx_pkt(1'b0, 32'h0000beef, 1'b1);
    level_is(6'h00);
    $display("test_np_credit done");
  endtask : test_np_credit
  task automatic test_saturate();
    hold_cr = 1'b1;
    tick(40);
    level_is(6'h20);
    hold_cr = 1'b0;
    rx_pkt(1'b1, 32'h5a5a0000, 1'b1);
    tick(2);
    level_is(6'h1f);
    $display("test_saturate done");
  endtask : test_saturate
  task automatic test_tx_credit();
    for (int k = 1; k <= 4; k++) begin
      nph_ret = 1'b1;
      npd_ret = 1'b1;
      tick(1);
      nph_ret = 1'b0;
      npd_ret = 1'b0;
      tick(4);
      check("hdr avail", 32'(hav), 32'(enc(k)));
      check("pld avail", 32'(dav), 32'(enc(k)));
    end
    for (int i = 0; i <= 4; i++) begin
      send_req = 1'b1;
      send_pld = 1'b1;
      #1;
      check("np_send_ack_o", 32'(send_ack), 32'(i < 4));
      tick(1);
      send_req = 1'b0;
      tick(5);
      check("hdr used", 32'(hav), 32'(enc(i < 4 ? 3 - i : 0)));
      check("pld used", 32'(dav), 32'(enc(i < 4 ? 3 - i : 0)));
    end
    // Two credits, then back-to-back sends inside the indicator lag
    nph_ret = 1'b1;
    npd_ret = 1'b1;
    tick(2);
    nph_ret = 1'b0;
    npd_ret = 1'b0;
    tick(4);
    check("hdr two", 32'(hav), 32'(enc(2)));
    send_req = 1'b1;
    send_pld = 1'b1;
    for (int j = 0; j < 4; j++) begin
      #1;
      check("ack burst", 32'(send_ack), 32'(j < 2));
      tick(1);
    end
    send_req = 1'b0;
    tick(4);
    check("hdr burst", 32'(hav), 32'(enc(0)));
    check("pld burst", 32'(dav), 32'(enc(0)));
    $display("test_tx_credit done");
  endtask : test_tx_credit
  task automatic test_tag();
    int n;
    n         = 0;
    cpl_tag   = 8'h5a;
    cpl_valid = 1'b1;
    tick(1);
    cpl_valid = 1'b0;
    check("sideband", 32'(sband), 32'h1);
    while (tag_free !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    check("tag guard", 32'(n >= 5 && n < 20), 32'h1);
    check("tag_free_id_o", 32'(free_id), 32'h5a);
    $display("test_tag done");
  endtask : test_tag
  initial begin
    do_reset();
    test_reset();
    test_np_credit();
    test_saturate();
    test_tx_credit();
    test_tag();
    do_reset();
    test_reset();
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
